/* otp_pkg.sv */
// constants for the power-down termination transition controller
package otp_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // analog turn-on/off bounds in picoseconds (2 ns and 8.5 ns)
  localparam int unsigned ASYNC_MIN_PS = 2000;
  localparam int unsigned ASYNC_MAX_PS = 8500;
  // least time rounds up, longest rounds down, never below one cycle
  localparam int unsigned ASYNC_MIN_CYC_RAW = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ASYNC_MAX_CYC_RAW = ASYNC_MAX_PS / CLK_PERIOD_PS;
  localparam int unsigned ASYNC_MIN_CYC = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
  localparam int unsigned ASYNC_MAX_CYC = (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] ODTL_OFFSET = 8'h02;
  localparam logic [CNT_W-1:0] ANPD_OFFSET = 8'h01;
  localparam logic [CNT_W-1:0] ONE_CYC = 8'h01;
  localparam logic [CNT_W-1:0] ASYNC_MAX_CNT = CNT_W'(ASYNC_MAX_CYC);
  // synchronous late extra beyond the odt latency, in cycles
  localparam logic [CNT_W-1:0] SYNC_LATE_EXTRA = 8'h01;
  typedef enum logic [2:0] {
    OTP_ACTIVE, OTP_ENTRY, OTP_PD, OTP_EXIT
  } otp_state_e;
endpackage : otp_pkg

/* otp_down_cnt.sv */
// loadable down counter used for uncertainty timing
`timescale 1ns/1ps
module otp_down_cnt
  import otp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // control
  input wire logic load_in,
  input wire logic [CNT_W-1:0] value_in,
  // status
  output logic busy_out
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= 8'h00;
    end else if (load_in) begin
      cnt_r <= value_in;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - ONE_CYC;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
    end else if (load_in) begin
      busy_out <= (value_in != 8'h00);
    end else begin
      busy_out <= (cnt_r > ONE_CYC);
    end
  end
endmodule : otp_down_cnt

/* otp_ctrl.sv */
// controller that sequences cke/odt around power-down and tracks termination certainty
//
// Summary of operation
// - the entry window opens tANPD before cke is first sampled low and ends at that edge.
// - tANPD in cycles is write latency minus one.
// - with a refresh in flight at cke fall, entry ends tRFC after the refresh command.
// - odt raised in the entry window turns termination on between min(2ns,sync) and max(8.5ns,sync).
// - odt dropped in the entry window turns termination off in the same mixed bounds.
// - odt changes after entry closes are asynchronous, before it opens synchronous.
// - the exit window spans tANPD before cke is first sampled high to tXPDLL after it; the controller opens it at cke rise for tANPD + tXPDLL.
// - odt raised in the exit window turns on within the mixed asynchronous/synchronous bounds.
// - odt dropped in the exit window turns off within the mixed bounds.
// - after the exit window odt is synchronous again, before it asynchronous.
// - a short cke low pulse merges entry and exit windows, but the window flag drops for the power-down cycle unless a refresh is in flight.
// - a short cke high pulse merges exit and next entry windows into one uncertain span.
`timescale 1ns/1ps
module otp_ctrl
  import otp_pkg::*;
#(
  parameter logic [CNT_W-1:0] TRFC_CYC = 8'h0c,
  parameter logic [CNT_W-1:0] TXPDLL_CYC = 8'h0a
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // configuration
  input wire logic dll_off_pd_n_in,
  input wire logic [CNT_W-1:0] cwl_in,
  input wire logic [CNT_W-1:0] al_in,
  // user requests
  input wire logic pd_req_in,
  input wire logic odt_req_in,
  input wire logic refresh_in,
  // memory pins
  output logic cke_out,
  output logic odt_out,
  // status
  output logic in_window_out,
  output logic rtt_unknown_out,
  output logic rtt_on_out,
  output logic xfer_ok_out,
  output logic pd_active_out
);
  // ----------------------------------------------------------------
  // latencies
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] wl;
  logic [CNT_W-1:0] odtl;
  logic [CNT_W-1:0] anpd;
  logic mixed;
  assign wl = CNT_W'(cwl_in + al_in);
  assign odtl = wl - ODTL_OFFSET;
  assign anpd = wl - ANPD_OFFSET;
  assign mixed = ~dll_off_pd_n_in;

  // ----------------------------------------------------------------
  // state and counters
  // ----------------------------------------------------------------
  otp_state_e state_r;
  otp_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] rfc_r;
  logic odt_prev_r;
  logic unc_load;
  logic [CNT_W-1:0] unc_len;
  logic unc_busy;
  logic win_nxt;
  logic exit_start;
  logic [CNT_W-1:0] sync_len;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      OTP_ACTIVE: begin
        if (pd_req_in && !refresh_in) begin
          state_nxt = OTP_ENTRY;
        end
      end
      OTP_ENTRY: begin
        if (!pd_req_in) begin
          state_nxt = OTP_EXIT;
        end else if (cnt_r == 8'h00) begin
          state_nxt = OTP_PD;
        end
      end
      OTP_PD: begin
        if (!pd_req_in && rfc_r == 8'h00) begin
          state_nxt = OTP_EXIT;
        end
      end
      OTP_EXIT: begin
        if (pd_req_in && cnt_r > TXPDLL_CYC) begin
          state_nxt = OTP_ENTRY;
        end else if (cnt_r == 8'h00) begin
          state_nxt = OTP_ACTIVE;
        end
      end
      default: state_nxt = OTP_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= OTP_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // window counter: entry holds tANPD, exit tANPD + tXPDLL
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= 8'h00;
    end else if (state_nxt == OTP_ENTRY && state_r != OTP_ENTRY) begin
      cnt_r <= anpd;
    end else if (state_nxt == OTP_EXIT && state_r != OTP_EXIT) begin
      cnt_r <= CNT_W'(anpd + TXPDLL_CYC);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - ONE_CYC;
    end
  end

  // refresh in flight stretches entry to tRFC after the command
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rfc_r <= 8'h00;
    end else if (refresh_in && state_r == OTP_ACTIVE) begin
      rfc_r <= TRFC_CYC;
    end else if (rfc_r != 8'h00) begin
      rfc_r <= rfc_r - ONE_CYC;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cke_out <= 1'b1;
    end else begin
      // cke drops only once the entry lead time has run out
      cke_out <= !(state_nxt == OTP_PD);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      odt_out <= 1'b0;
      odt_prev_r <= 1'b0;
    end else begin
      odt_out <= odt_req_in;
      odt_prev_r <= odt_out;
    end
  end

  // ----------------------------------------------------------------
  // termination certainty
  // ----------------------------------------------------------------
  // entry/exit chain directly, but the window flag drops for any power-down cycle with no refresh in flight
  assign win_nxt = mixed && (state_r == OTP_ENTRY || state_r == OTP_EXIT ||
                   (state_r == OTP_PD && rfc_r != 8'h00));

  // odt moved late in power-down may still answer synchronously, so cke rise restarts the span
  assign exit_start = mixed && state_r == OTP_PD && state_nxt == OTP_EXIT;
  assign sync_len = CNT_W'(odtl + SYNC_LATE_EXTRA);

  // an edge on odt opens an uncertainty span whose length depends on mode
  assign unc_load = (odt_out != odt_prev_r) || exit_start;
  always_comb begin
    if (win_nxt || exit_start) begin
      // mixed: latest of analog max and synchronous late bound
      unc_len = (ASYNC_MAX_CNT > sync_len) ?
                ASYNC_MAX_CNT : sync_len;
    end else if (state_r == OTP_PD && mixed) begin
      unc_len = ASYNC_MAX_CNT;
    end else begin
      unc_len = sync_len;
    end
  end

  otp_down_cnt u_unc (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(unc_load),
    .value_in(unc_len),
    .busy_out(unc_busy)
  );

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      in_window_out <= 1'b0;
      rtt_unknown_out <= 1'b0;
      rtt_on_out <= 1'b0;
      xfer_ok_out <= 1'b0;
      pd_active_out <= 1'b0;
    end else begin
      in_window_out <= win_nxt;
      rtt_unknown_out <= unc_busy || unc_load;
      if (!unc_busy && !unc_load) begin
        rtt_on_out <= odt_out;
      end
      xfer_ok_out <= !unc_busy && !unc_load && state_r == OTP_ACTIVE;
      pd_active_out <= (state_nxt == OTP_PD);
    end
  end
endmodule : otp_ctrl

/* otp_ctrl_asserts.sv */
// checker for the termination transition controller
`timescale 1ns/1ps
module otp_ctrl_asserts
  import otp_pkg::*;
#(
  parameter logic [CNT_W-1:0] TRFC_CYC = 8'h0c,
  parameter logic [CNT_W-1:0] TXPDLL_CYC = 8'h0a
) (
  // watched ports
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic dll_off_pd_n_in,
  input wire logic [CNT_W-1:0] cwl_in,
  input wire logic [CNT_W-1:0] al_in,
  input wire logic pd_req_in,
  input wire logic odt_req_in,
  input wire logic refresh_in,
  input wire logic cke_out,
  input wire logic odt_out,
  input wire logic in_window_out,
  input wire logic rtt_unknown_out,
  input wire logic rtt_on_out,
  input wire logic xfer_ok_out,
  input wire logic pd_active_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [CNT_W-1:0] win_r;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) win_r <= 8'h00;
    else win_r <= in_window_out ? win_r + 8'h01 : 8'h00;
  end
  odt_unknown_a: assert property ($changed(odt_out) |=> rtt_unknown_out) else $error("no unknown");
  xfer_hold_a: assert property (rtt_unknown_out |-> !xfer_ok_out) else $error("xfer while unknown");
  pd_cke_a: assert property (pd_active_out |-> !cke_out) else $error("cke high in pd");
  mixed_only_a: assert property (dll_off_pd_n_in |-> !in_window_out) else $error("window dll on");
  entry_len_a:
    assert property ($fell(cke_out) && !dll_off_pd_n_in |-> win_r >= cwl_in + al_in - 8'h01)
    else $error("entry window short");
  exit_win_a:
    assert property ($rose(cke_out) && !dll_off_pd_n_in |=> in_window_out ##1 in_window_out)
    else $error("exit window short");
  sync_unc_a:
    assert property ($rose(rtt_unknown_out) && !in_window_out && cke_out |-> rtt_unknown_out[*3])
    else $error("sync uncertainty short");
  settle_a: assert property ($fell(rtt_unknown_out) |-> rtt_on_out == odt_out) else $error("bad settle");
  exit_soon_a: assert property (pd_active_out && !pd_req_in |-> ##[1:40] cke_out)
    else $error("no exit");
endmodule : otp_ctrl_asserts
bind otp_ctrl otp_ctrl_asserts #(.TRFC_CYC(TRFC_CYC), .TXPDLL_CYC(TXPDLL_CYC)) chk (.clk_in,
  .sys_rst_in, .dll_off_pd_n_in, .cwl_in, .al_in, .pd_req_in, .odt_req_in, .refresh_in, .cke_out,
  .odt_out, .in_window_out, .rtt_unknown_out, .rtt_on_out, .xfer_ok_out, .pd_active_out);

/* otp_dram_model.sv */
// behavioural termination model of the memory device
`timescale 1ns/1ps
module otp_dram_model
  import otp_pkg::*;
(
  // memory pins and odt latency
  input wire logic clk_in,
  input wire logic cke_in,
  input wire logic odt_in,
  input wire logic [CNT_W-1:0] odtl_in,
  // settled termination
  output logic rtt_out
);
  logic [15:0] pipe_r;
  always_ff @(posedge clk_in) begin
    pipe_r <= {pipe_r[14:0], odt_in};
    // analog delay is under one cycle, ignores al
    if (!cke_in) rtt_out <= odt_in;
    else rtt_out <= pipe_r[odtl_in - 8'h01];
  end
endmodule : otp_dram_model

/* tb_otp_ctrl.sv */
// self-checking bench for the termination transition controller
`timescale 1ns/1ps
module tb_otp_ctrl;
  import otp_pkg::*;
  localparam logic [CNT_W-1:0] TXP = 8'h02;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic dll_off_pd_n_in = 1'b0;
  logic [CNT_W-1:0] cwl_in = 8'h05;
  logic [CNT_W-1:0] al_in = 8'h00;
  logic pd_req_in = 1'b0;
  logic odt_req_in = 1'b0;
  logic refresh_in = 1'b0;
  logic cke_out, odt_out, in_window_out, rtt_unknown_out, rtt_on_out, xfer_ok_out;
  logic pd_active_out, rtt_m;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  always #12.5 clk_in = ~clk_in;
  otp_ctrl #(.TRFC_CYC(8'h0c), .TXPDLL_CYC(TXP)) uut (.clk_in, .sys_rst_in, .dll_off_pd_n_in,
    .cwl_in, .al_in, .pd_req_in, .odt_req_in, .refresh_in, .cke_out, .odt_out, .in_window_out,
    .rtt_unknown_out, .rtt_on_out, .xfer_ok_out, .pd_active_out);
  otp_dram_model dram (.clk_in, .cke_in(cke_out), .odt_in(odt_out),
    .odtl_in(cwl_in + al_in - 8'h02), .rtt_out(rtt_m));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic do_reset(input logic dll);
    sys_rst_in = 1'b1;
    dll_off_pd_n_in = dll;
    tick(10);
    sys_rst_in = 1'b0;
  endtask : do_reset
  // counts window cycles until cke reaches v
  task automatic wait_cke(input logic v);
    n = 0;
    for (int i = 0; i < 60 && cke_out !== v; i++) begin
      tick(1);
      if (in_window_out === 1'b1) n++;
    end
  endtask : wait_cke
  task automatic t_sync;
    odt_req_in = 1'b1;
    tick(2);
    check(rtt_unknown_out, 1'b1);
    check(xfer_ok_out, 1'b0);
    tick(10);
    check(rtt_on_out, 1'b1);
    check(rtt_on_out, rtt_m);
    check(xfer_ok_out, 1'b1);
    $display("sync odt done");
  endtask : t_sync
  task automatic t_pd(input logic dll);
    refresh_in = 1'b1;
    pd_req_in = 1'b1;
    tick(1);
    refresh_in = 1'b0;
    wait_cke(1'b0);
    check(cke_out, 1'b0);
    check(n >= cwl_in + al_in - 8'h01, !dll);
    tick(1);
    check(pd_active_out, 1'b1);
    odt_req_in = 1'b0;
    tick(3);
    // refresh still running keeps the entry window open
    check(in_window_out, !dll);
    tick(4);
    check(rtt_on_out, 1'b0);
    check(rtt_m, 1'b0);
    pd_req_in = 1'b0;
    wait_cke(1'b1);
    check(cke_out, 1'b1);
    // window flag is registered, so it shows one cycle after cke rises
    tick(1);
    for (n = 0; n < 60 && in_window_out === 1'b1; n++) tick(1);
    check(n >= cwl_in + al_in - 8'h01 + TXP, !dll);
    odt_req_in = 1'b1;
    tick(12);
    check(rtt_on_out, 1'b1);
    check(xfer_ok_out, 1'b1);
    $display("power-down cycle done");
  endtask : t_pd
  task automatic t_short;
    pd_req_in = 1'b1;
    tick(2);
    pd_req_in = 1'b0;
    odt_req_in = 1'b0;
    tick(2);
    check(cke_out, 1'b1);
    check(rtt_unknown_out, 1'b1);
    // entry aborted before cke fell: exit turns straight back into entry
    pd_req_in = 1'b1;
    tick(1);
    check(in_window_out, 1'b1);
    wait_cke(1'b0);
    check(cke_out, 1'b0);
    // short cke low pulse: a single cycle of power-down
    pd_req_in = 1'b0;
    tick(1);
    check(cke_out, 1'b1);
    check(rtt_unknown_out, 1'b1);
    odt_req_in = 1'b1;
    tick(5);
    check(rtt_unknown_out, 1'b1);
    check(xfer_ok_out, 1'b0);
    tick(25);
    check(in_window_out, 1'b0);
    check(rtt_on_out, 1'b1);
    $display("short pulse done");
  endtask : t_short
  task automatic end_sim;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    do_reset(1'b0);
    t_sync();
    t_pd(1'b0);
    t_short();
    do_reset(1'b1);
    t_pd(1'b1);
    end_sim();
  end
endmodule : tb_otp_ctrl
